// ### rtl/asr_pkg.sv
// package for the static ram host controller: pin bundle, timing and grade constants
package asr_pkg;
  localparam int ADDR_W        = 12;
  localparam int DEPTH         = 4096;
  localparam int CLK_PERIOD_NS = 50;
  // slowest documented grade, so one table fits all four
  localparam int READ_CYCLE_TIME_NS      = 70;
  localparam int SELECT_ACCESS_TIME_NS   = 70;
  localparam int SELECT_TO_WRITE_END_NS  = 55;
  localparam int ADDRESS_TO_WRITE_END_NS = 55;
  localparam int WRITE_PULSE_NS          = 40;
  localparam int WRITE_RECOVERY_NS       = 15;
  localparam int DATA_HOLD_NS            = 10;
  localparam int DESELECT_TO_FLOAT_NS    = 40;
  localparam int DESELECT_TO_RETENTION_NS = 0;
  // least times round up
  localparam int ACCESS_CYC = (SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC  =
    (SELECT_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC  = (DESELECT_TO_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              data_in;
    logic              select_n;
    logic              write_en_n;
  } asr_pins_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic              wdata;
  } asr_req_t;
endpackage : asr_pkg

// ### rtl/asr_wait_cnt.sv
// down counter that times each phase of a ram cycle after the one-cycle setup
module asr_wait_cnt #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cnt_r <= '0;
    else if (load)
      cnt_r <= value;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  // done ignores load so the phase logic that drives load forms no loop
  assign done = (cnt_r == '0);
endmodule : asr_wait_cnt

// ### rtl/asr_host.sv
// host controller driving a 4096 x 1 asynchronous static ram through its pins
// Operation
// R1: ram holds 4096 one-bit locations
// R2: separate data in, three-state data out
// R3: ram fully static, no clock needed
// R4: read holds write enable high, select low
// R5: read cycle lasts at least access time
// R6: old data held 5 ns after address
// R7: data valid within select access time
// R8: address stable before select falls
// R9: output floats at least 10/5 ns
// R10: output floats within 40/30 ns of deselect
// R11: fast grades turn off before turn on
// R12: standby after deselect, instant power up
// R13: short deselect does not slow access
// R14: write enable low floats output
// R15: output may drive after write end
// R16: select and write rise together, stay floating
// R17: address changes only while strobe high
// R18: select low long enough before write end
// R19: address valid long enough before write end
// R20: write ended by either strobe accepted
// R21: deselect before retention, wait recovery cycle
// R22: ram stores data at first rising strobe
module asr_host #(
  parameter int ACCESS_CYCLES  = asr_pkg::ACCESS_CYC,
  parameter int WRITE_CYCLES   = asr_pkg::WRITE_CYC,
  parameter int FLOAT_CYCLES   = asr_pkg::FLOAT_CYC,
  parameter int RECOVER_CYCLES = asr_pkg::RECOVER_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire asr_pkg::asr_req_t          req,
  output logic                            rsp_valid,
  output logic                            rsp_rdata,
  input  wire logic                       retention_req,
  output logic                            retention_ok,
  output asr_pkg::asr_pins_t              pins,
  input  wire logic                       ram_data_out
);
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_SETUP   = 6'h02,
    ST_READ    = 6'h04,
    ST_WRITE   = 6'h08,
    ST_RECOVER = 6'h10,
    ST_RETAIN  = 6'h20
  } asr_state_t;

  localparam logic [asr_pkg::CNT_W-1:0] ACC_V = asr_pkg::CNT_W'(ACCESS_CYCLES);
  localparam logic [asr_pkg::CNT_W-1:0] WR_V  = asr_pkg::CNT_W'(WRITE_CYCLES);
  localparam logic [asr_pkg::CNT_W-1:0] FLT_V = asr_pkg::CNT_W'(FLOAT_CYCLES);
  localparam logic [asr_pkg::CNT_W-1:0] REC_V = asr_pkg::CNT_W'(RECOVER_CYCLES);

  asr_state_t         state_r;
  asr_state_t         state_nxt;
  asr_pkg::asr_pins_t pins_r;
  asr_pkg::asr_pins_t pins_nxt;
  logic               rsp_valid_r;
  logic               rdata_r;
  logic               write_r;
  logic               cnt_load;
  logic [asr_pkg::CNT_W-1:0] cnt_value;
  logic               cnt_done;

  asr_wait_cnt #(.W(asr_pkg::CNT_W)) u_cnt (
    .clk_sys (clk_sys),
    .reset   (reset),
    .load    (cnt_load),
    .value   (cnt_value),
    .done    (cnt_done)
  );

  wire is_idle   = (state_r == ST_IDLE);
  wire take_req  = is_idle && req_valid && !retention_req;
  wire go_retain = is_idle && retention_req;
  wire phase_end = cnt_done;
  assign req_ready    = is_idle && !retention_req;
  assign retention_ok = (state_r == ST_RETAIN) && cnt_done;
  assign rsp_valid    = rsp_valid_r;
  assign rsp_rdata    = rdata_r;
  assign pins         = pins_r;

  always_comb
  begin
    state_nxt = state_r;
    pins_nxt  = pins_r;
    cnt_load  = 1'b0;
    cnt_value = '0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (take_req)
        begin
          // address and data set while both strobes are high [R17] [R8]
          pins_nxt.addr       = req.addr;
          pins_nxt.data_in    = req.wdata;
          pins_nxt.select_n   = 1'b1;
          pins_nxt.write_en_n = 1'b1;
          state_nxt           = ST_SETUP;
        end
        else if (go_retain)
        begin
          // deselect ahead of supply drop, then hold one read cycle [R21]
          pins_nxt.select_n   = 1'b1;
          pins_nxt.write_en_n = 1'b1;
          cnt_load            = 1'b1;
          cnt_value           = REC_V;
          state_nxt           = ST_RETAIN;
        end
      end
      ST_SETUP:
      begin
        // select falls after address is stable [R8]
        pins_nxt.select_n   = 1'b0;
        pins_nxt.write_en_n = !write_r; // [R4] [R20]
        cnt_load            = 1'b1;
        cnt_value           = write_r ? WR_V : ACC_V; // [R5] [R18] [R19]
        state_nxt           = write_r ? ST_WRITE : ST_READ;
      end
      ST_READ:
      begin
        if (phase_end)
        begin
          pins_nxt.select_n = 1'b1;
          cnt_load          = 1'b1;
          cnt_value         = FLT_V; // bus turnaround before next select [R10]
          state_nxt         = ST_RECOVER;
        end
      end
      ST_WRITE:
      begin
        if (phase_end)
        begin
          // both strobes rise together; output stays floating [R16] [R22]
          pins_nxt.select_n   = 1'b1;
          pins_nxt.write_en_n = 1'b1;
          cnt_load            = 1'b1;
          cnt_value           = FLT_V;
          state_nxt           = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        if (phase_end)
          state_nxt = ST_IDLE;
      end
      ST_RETAIN:
      begin
        if (!retention_req && cnt_done)
        begin
          cnt_load  = 1'b1;
          cnt_value = REC_V; // wait a read cycle after recovery [R21]
          state_nxt = ST_RECOVER;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      pins_r  <= '{addr: '0, data_in: 1'b0, select_n: 1'b1, write_en_n: 1'b1};
      write_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      pins_r  <= pins_nxt;
      if (take_req)
        write_r <= req.write;
    end
  end

  // data sampled at end of access time, before deselect [R5] [R7]
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rsp_valid_r <= 1'b0;
      rdata_r     <= 1'b0;
    end
    else
    begin
      rsp_valid_r <= (state_r == ST_READ) && phase_end;
      if ((state_r == ST_READ) && phase_end)
        rdata_r <= ram_data_out;
    end
  end

  AST_READ_WE_HIGH: assert property (@(posedge clk_sys) disable iff (reset) // [R4]
    (state_r == ST_READ) |-> (pins_r.write_en_n && !pins_r.select_n))
    else $error("write enable low during read");

  AST_ADDR_STABLE: assert property (@(posedge clk_sys) disable iff (reset) // [R17]
    (!pins_r.select_n && !pins_r.write_en_n) |=> $stable(pins_r.addr) || pins_r.select_n)
    else $error("address moved during write strobe");

  AST_SEL_AFTER_ADDR: assert property (@(posedge clk_sys) disable iff (reset) // [R8]
    $fell(pins_r.select_n) |-> $stable(pins_r.addr))
    else $error("address changed with select fall");

  AST_WRITE_LEN: assert property (@(posedge clk_sys) disable iff (reset) // [R18]
    $rose(pins_r.write_en_n) |-> $past(!pins_r.select_n, WRITE_CYCLES))
    else $error("select too short before write end");

  AST_WRITE_ADDR: assert property (@(posedge clk_sys) disable iff (reset) // [R19]
    $rose(pins_r.write_en_n) |-> $past(pins_r.addr, WRITE_CYCLES) == pins_r.addr)
    else $error("address not valid long enough");

  AST_WRITE_END: assert property (@(posedge clk_sys) disable iff (reset) // [R20]
    $rose(pins_r.write_en_n) |-> $rose(pins_r.select_n))
    else $error("write not ended by both strobes");

  sequence s_read_done;
    (state_r == ST_READ) && phase_end;
  endsequence
  AST_READ_LEN: assert property (@(posedge clk_sys) disable iff (reset) // [R5]
    s_read_done |-> $past(!pins_r.select_n, ACCESS_CYCLES) ##1 rsp_valid)
    else $error("read shorter than access time");

  AST_RETAIN: assert property (@(posedge clk_sys) disable iff (reset) // [R21]
    retention_ok |-> pins_r.select_n && $past(pins_r.select_n, RECOVER_CYCLES))
    else $error("retention granted while selected");
endmodule : asr_host

// ### dv/asr_ram_model.sv
// behavioural 4096 x 1 static ram that sits on the far pins of the host
module asr_ram_model #(
  parameter int ACC_NS = 70
) (
  input  wire asr_pkg::asr_pins_t pins,
  output logic                    ram_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic                      mem [asr_pkg::DEPTH];
  logic                      rd_sel;
  wire                       drv;
  wire                       rd_bit;
  logic                      hold;
  logic                      armed;
  logic [asr_pkg::ADDR_W-1:0] wa;
  logic                      wd;
  initial armed = 1'b0;
  assign rd_sel = !pins.select_n && pins.write_en_n;
  // drive starts a full access time after select, stops at once
  assign #(ACC_NS, 0) drv = rd_sel;
  always @*
  begin
    if (!pins.select_n && !pins.write_en_n)
    begin
      armed = 1'b1;
      wa = pins.addr;
      wd = pins.data_in;
    end
  end
  // store at whichever strobe rises first
  always @(posedge pins.select_n or posedge pins.write_en_n)
  begin
    if (armed)
      mem[wa] = wd;
    armed = 1'b0;
  end
  always @*
  begin
    if (drv)
      hold = mem[pins.addr];
  end
  // old bit stays valid 5 ns after an address move
  assign #(5) rd_bit = mem[pins.addr];
  // a floating output shows the inverse of the last bit
  assign ram_data_out = drv ? rd_bit : ~hold;
endmodule : asr_ram_model

// ### dv/asr_host_tb.sv
// self-checking bench for the static ram host controller
module asr_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_sys = 1'b0;
  logic               reset = 1'b1;
  logic               req_valid = 1'b0;
  logic               req_ready;
  asr_pkg::asr_req_t  req = '0;
  logic               rsp_valid;
  logic               rsp_rdata;
  logic               retention_req = 1'b0;
  logic               retention_ok;
  asr_pkg::asr_pins_t pins;
  logic               ram_data_out;
  logic               ref_mem [asr_pkg::DEPTH];
  logic               exp_q [$];
  int                 n_fail = 0;
  int                 n_compared = 0;
  int                 seed = 96;
  logic [11:0]        addr_list [8];
  always #25 clk_sys = ~clk_sys;
  asr_host i_dut (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .req_valid     (req_valid),
    .req_ready     (req_ready),
    .req           (req),
    .rsp_valid     (rsp_valid),
    .rsp_rdata     (rsp_rdata),
    .retention_req (retention_req),
    .retention_ok  (retention_ok),
    .pins          (pins),
    .ram_data_out  (ram_data_out)
  );
  asr_ram_model i_ram (
    .pins         (pins),
    .ram_data_out (ram_data_out)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // entered at a falling edge; holds the request until the edge that takes it
  task automatic do_req(input logic w, input logic [11:0] a, input logic d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{write: w, addr: a, wdata: d};
    while (req_ready !== 1'b1 && n < 40)
    begin
      @(negedge clk_sys);
      n++;
    end
    // ready stood high at the falling edge, so this rising edge takes it
    @(posedge clk_sys);
    check(16'(n < 40), 16'h0001);
    if (w)
      ref_mem[a] = d;
    else
      exp_q.push_back(ref_mem[a]);
    @(negedge clk_sys);
  endtask : do_req
  // read results are matched against the oldest expectation
  always @(negedge clk_sys)
  begin
    if (rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(16'h0001, 16'h0000);
      else
        check(16'(rsp_rdata), 16'(exp_q.pop_front()));
    end
  end
  initial
  begin
    #(50 * 20000);
    n_fail++;
    complete_run();
  end
  initial
  begin
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    do_req(1'b1, 12'h000, 1'b1);
    do_req(1'b1, 12'hFFF, 1'b0);
    do_req(1'b1, 12'hFFF, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      addr_list[i] = 12'($random(seed));
      do_req(1'b1, addr_list[i], 1'($random(seed)));
    end
    do_req(1'b0, 12'hFFF, 1'b0);
    do_req(1'b0, 12'h000, 1'b0);
    for (int i = 0; i < 8; i++)
      do_req(1'b0, addr_list[i], 1'b0);
    req_valid = 1'b0;
    repeat (12) @(negedge clk_sys);
    retention_req = 1'b1;
    for (int n = 0; n < 20 && retention_ok !== 1'b1; n++)
      @(negedge clk_sys);
    check(16'(retention_ok), 16'h0001);
    check(16'(pins.select_n), 16'h0001);
    check(16'(req_ready), 16'h0000);
    retention_req = 1'b0;
    do_req(1'b0, 12'hFFF, 1'b0);
    do_req(1'b0, addr_list[7], 1'b0);
    req_valid = 1'b0;
    repeat (12) @(negedge clk_sys);
    check(16'(exp_q.size()), 16'h0000);
    complete_run();
  end
endmodule : asr_host_tb
